// *** core/ascr_pkg.sv ***
// Constants and types for the addressed serial command responder
package ascr_pkg;
	localparam int          CLK_HZ       = 25_000_000;
	localparam int          BAUD_DEF     = 115_200;
	localparam logic [15:0] DIV_RST      = 16'(CLK_HZ / BAUD_DEF - 1);
	localparam int          HOST_GAP_US  = 2000;
	localparam int          HOST_GAP_CYC = (CLK_HZ / 1_000_000) * HOST_GAP_US;

	localparam logic [7:0] A_UNIT = 8'h00;
	localparam logic [7:0] A_LINE = 8'h04;
	localparam logic [7:0] A_WAIT = 8'h08;
	localparam logic [7:0] A_RESP = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_INFO = 8'h14;

	localparam logic [7:0]  CH_START   = 8'h02;
	localparam logic [7:0]  CH_END     = 8'h03;
	localparam logic [7:0]  UNIT_BCAST = 8'h7F;
	localparam logic [7:0]  UNIT_RST   = 8'h01;
	localparam logic [7:0]  RESP_RST   = 8'h00;
	localparam logic [15:0] WAIT_RST   = 16'h0014;

	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;

	localparam int         CHAR_W    = 12;
	localparam logic [3:0] BITS_ONE  = 4'h1;
	localparam logic [3:0] BITS_TWO  = 4'h2;
	localparam logic [3:0] BITS_D7   = 4'h7;
	localparam logic [3:0] BITS_D8   = 4'h8;
	localparam logic [2:0] IDX_START = 3'h0;
	localparam logic [2:0] IDX_UNIT  = 3'h1;
	localparam logic [2:0] IDX_CODE  = 3'h2;
	localparam logic [2:0] IDX_RESP  = 3'h3;
	localparam logic [2:0] IDX_LAST  = 3'h4;

	typedef struct packed {
		logic [11:0] rsv;
		logic        two_stop;
		logic [1:0]  parity;
		logic        data7;
		logic [15:0] div;
	} ascr_line_t;

	localparam ascr_line_t LINE_RST = '{rsv: 12'h000, two_stop: 1'b0,
		parity: PAR_NONE, data7: 1'b0, div: DIV_RST};

	typedef struct packed {
		logic [27:0] rsv;
		logic        tx_busy;
		logic        frm_err;
		logic        bcast;
		logic        pend;
	} ascr_stat_t;

	typedef struct packed {
		logic       bcast;
		logic [7:0] code;
		logic [7:0] arg;
	} ascr_cmd_t;

	typedef enum logic [4:0] {
		R_IDLE = 5'b00001, R_START = 5'b00010, R_DATA = 5'b00100,
		R_PAR = 5'b01000, R_STOP = 5'b10000
	} ascr_rx_st_t;

	typedef enum logic [4:0] {
		P_IDLE = 5'b00001, P_UNIT = 5'b00010, P_CMD = 5'b00100,
		P_ARG = 5'b01000, P_END = 5'b10000
	} ascr_ps_st_t;

	typedef enum logic [2:0] {
		T_IDLE = 3'b001, T_WAIT = 3'b010, T_SEND = 3'b100
	} ascr_tx_st_t;
endpackage

// *** core/ascr_responder.sv ***
// Addressed serial command responder with APB register slave
// Behaviour
// - Act on a frame whose unit number equals ours or is broadcast; answer it only when it equals ours.
// - A broadcast frame is carried out but never answered.
// - All nodes use the same baud rate, data length, stop bits and parity.
// - The response is held back by a programmable send-wait delay.
`timescale 1ns/1ps
module ascr_responder
	import ascr_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line
	input  wire logic        rx_pin,
	output logic             tx_pin,
	output logic             tx_oe,
	// Command output
	output logic             cmd_stb,
	output ascr_cmd_t        cmd_out
);

	function automatic logic [CHAR_W-1:0] mk_char(input logic [7:0] b,
			input ascr_line_t c);
		logic [CHAR_W-1:0] v;
		logic [7:0]        m;
		logic              p;
		v = '1;
		m = c.data7 ? {1'b0, b[6:0]} : b;
		p = (c.parity == PAR_ODD) ? ~^m : ^m;
		v[0] = 1'b0;
		if (c.data7) begin
			v[7:1] = m[6:0];
			if (c.parity != PAR_NONE)
				v[8] = p;
		end else begin
			v[8:1] = m;
			if (c.parity != PAR_NONE)
				v[9] = p;
		end
		return v;
	endfunction

	function automatic logic [3:0] char_len(input ascr_line_t c);
		return BITS_ONE + (c.data7 ? BITS_D7 : BITS_D8)
			+ {3'h0, c.parity != PAR_NONE}
			+ (c.two_stop ? BITS_TWO : BITS_ONE);
	endfunction

	// Register file state
	logic [7:0]   unit_q, unit_d;
	ascr_line_t   line_q, line_d;
	logic [15:0]  wait_q, wait_d;
	logic [7:0]   resp_q, resp_d;
	logic [31:0]  prdata_q, prdata_d, rd;
	logic         pready_q, pready_d;
	logic         pslverr_q, pslverr_d;
	logic         hit;
	// Receiver state
	logic         rx_s1_q, rx_s2_q;
	ascr_rx_st_t  rst_q, rst_d;
	logic [15:0]  rcnt_q, rcnt_d;
	logic [3:0]   rbit_q, rbit_d;
	logic [7:0]   rsh_q, rsh_d, rb_byte_q, rb_byte_d;
	logic         rpar_q, rpar_d, rb_stb_q, rb_stb_d, rb_err_q, rb_err_d;
	logic [7:0]   rbyte;
	// Frame parser state
	ascr_ps_st_t  pst_q, pst_d;
	logic [7:0]   punit_q, punit_d, pcode_q, pcode_d, parg_q, parg_d;
	ascr_cmd_t    cmd_q, cmd_d;
	logic         cmd_stb_q, cmd_stb_d, pend_q, pend_d, ferr_q, ferr_d;
	logic         go_tx, addr_me, addr_all;
	// Transmitter state
	ascr_tx_st_t  tst_q, tst_d;
	logic [15:0]  tcnt_q, tcnt_d, twait_q, twait_d;
	logic [CHAR_W-1:0] tsh_q, tsh_d;
	logic [3:0]   tbits_q, tbits_d;
	logic [2:0]   tidx_q, tidx_d;
	logic         tx_q, tx_d, tx_oe_q, tx_oe_d;
	logic [7:0]   tbyte;

	logic         sel_setup, wr, wr_stat;
	ascr_stat_t   stat, wst;

	assign sel_setup = psel & ~penable;
	assign wr        = psel & penable & pready_q & pwrite;
	assign wr_stat   = wr & (paddr == A_STAT);
	assign wst       = ascr_stat_t'(pwdata);
	assign stat      = '{rsv: 28'h0000000, tx_busy: tst_q != T_IDLE,
		frm_err: ferr_q, bcast: cmd_q.bcast, pend: pend_q};

	// Register file and APB answer
	always_comb begin
		unit_d    = unit_q;
		line_d    = line_q;
		wait_d    = wait_q;
		resp_d    = resp_q;
		pready_d  = sel_setup;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		rd        = '0;
		hit       = 1'b1;
		case (paddr)
			A_UNIT: rd = {24'h000000, unit_q};
			A_LINE: rd = line_q;
			A_WAIT: rd = {16'h0000, wait_q};
			A_RESP: rd = {24'h000000, resp_q};
			A_STAT: rd = stat;
			A_INFO: rd = {15'h0000, cmd_q};
			default: hit = 1'b0;
		endcase
		if (sel_setup) begin
			prdata_d  = rd;
			pslverr_d = ~hit;
		end
		if (wr) begin
			case (paddr)
				A_UNIT: unit_d = pwdata[7:0];
				A_LINE: begin
					line_d     = ascr_line_t'(pwdata);
					line_d.rsv = '0;
				end
				A_WAIT: wait_d = pwdata[15:0];
				A_RESP: resp_d = pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_q    <= UNIT_RST;
			line_q    <= LINE_RST;
			wait_q    <= WAIT_RST;
			resp_q    <= RESP_RST;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			unit_q    <= unit_d;
			line_q    <= line_d;
			wait_q    <= wait_d;
			resp_q    <= resp_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Character receiver
	assign rbyte = line_q.data7 ? {1'b0, rsh_q[7:1]} : rsh_q;

	always_comb begin
		rst_d     = rst_q;
		rcnt_d    = rcnt_q;
		rbit_d    = rbit_q;
		rsh_d     = rsh_q;
		rpar_d    = rpar_q;
		rb_byte_d = rb_byte_q;
		rb_stb_d  = 1'b0;
		rb_err_d  = 1'b0;
		case (rst_q)
			R_IDLE: if (!rx_s2_q) begin
				rcnt_d = {1'b0, line_q.div[15:1]};
				rst_d  = R_START;
			end
			R_START: if (rcnt_q == '0) begin
				rcnt_d = line_q.div;
				rbit_d = '0;
				rsh_d  = '0;
				rst_d  = rx_s2_q ? R_IDLE : R_DATA;
			end else
				rcnt_d = rcnt_q - 16'h0001;
			R_DATA: if (rcnt_q == '0) begin
				rcnt_d = line_q.div;
				rsh_d  = {rx_s2_q, rsh_q[7:1]};
				rbit_d = rbit_q + BITS_ONE;
				if (rbit_q == (line_q.data7 ? BITS_D7 : BITS_D8) - BITS_ONE)
					rst_d = (line_q.parity == PAR_NONE) ? R_STOP : R_PAR;
			end else
				rcnt_d = rcnt_q - 16'h0001;
			R_PAR: if (rcnt_q == '0) begin
				rcnt_d = line_q.div;
				rpar_d = rx_s2_q;
				rst_d  = R_STOP;
			end else
				rcnt_d = rcnt_q - 16'h0001;
			R_STOP: if (rcnt_q == '0) begin
				rb_stb_d  = 1'b1;
				rb_byte_d = rbyte;
				rb_err_d  = ~rx_s2_q | ((line_q.parity != PAR_NONE)
					& (rpar_q != ((line_q.parity == PAR_ODD) ? ~^rbyte
					: ^rbyte)));
				rst_d     = R_IDLE;
			end else
				rcnt_d = rcnt_q - 16'h0001;
			default: rst_d = R_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rst_q     <= R_IDLE;
			rcnt_q    <= '0;
			rbit_q    <= '0;
			rsh_q     <= '0;
			rpar_q    <= 1'b0;
			rb_byte_q <= '0;
			rb_stb_q  <= 1'b0;
			rb_err_q  <= 1'b0;
		end else if (ce) begin
			rx_s1_q   <= rx_pin;
			rx_s2_q   <= rx_s1_q;
			rst_q     <= rst_d;
			rcnt_q    <= rcnt_d;
			rbit_q    <= rbit_d;
			rsh_q     <= rsh_d;
			rpar_q    <= rpar_d;
			rb_byte_q <= rb_byte_d;
			rb_stb_q  <= rb_stb_d;
			rb_err_q  <= rb_err_d;
		end
	end

	// Frame parser and command status
	assign addr_me  = punit_q == unit_q;
	assign addr_all = punit_q == UNIT_BCAST;

	always_comb begin
		pst_d     = pst_q;
		punit_d   = punit_q;
		pcode_d   = pcode_q;
		parg_d    = parg_q;
		cmd_d     = cmd_q;
		cmd_stb_d = 1'b0;
		go_tx     = 1'b0;
		pend_d    = pend_q & ~(wr_stat & wst.pend);
		ferr_d    = ferr_q & ~(wr_stat & wst.frm_err);
		if (rb_stb_q) begin
			if (rb_err_q) begin
				pst_d  = P_IDLE;
				ferr_d = 1'b1;
			end else if (rb_byte_q == CH_START)
				pst_d = P_UNIT;
			else begin
				case (pst_q)
					P_UNIT: begin
						punit_d = rb_byte_q;
						pst_d   = P_CMD;
					end
					P_CMD: begin
						pcode_d = rb_byte_q;
						pst_d   = P_ARG;
					end
					P_ARG: begin
						parg_d = rb_byte_q;
						pst_d  = P_END;
					end
					P_END: begin
						pst_d = P_IDLE;
						if (rb_byte_q == CH_END && (addr_me || addr_all)) begin
							cmd_stb_d = 1'b1;
							cmd_d     = '{bcast: addr_all, code: pcode_q,
								arg: parg_q};
							pend_d    = 1'b1;
							go_tx     = ~addr_all;
						end
					end
					default: pst_d = P_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pst_q     <= P_IDLE;
			punit_q   <= '0;
			pcode_q   <= '0;
			parg_q    <= '0;
			cmd_q     <= '0;
			cmd_stb_q <= 1'b0;
			pend_q    <= 1'b0;
			ferr_q    <= 1'b0;
		end else if (ce) begin
			pst_q     <= pst_d;
			punit_q   <= punit_d;
			pcode_q   <= pcode_d;
			parg_q    <= parg_d;
			cmd_q     <= cmd_d;
			cmd_stb_q <= cmd_stb_d;
			pend_q    <= pend_d;
			ferr_q    <= ferr_d;
		end
	end

	// Response transmitter
	always_comb begin
		case (tidx_q + 3'h1)
			IDX_UNIT: tbyte = unit_q;
			IDX_CODE: tbyte = cmd_q.code;
			IDX_RESP: tbyte = resp_q;
			IDX_LAST: tbyte = CH_END;
			default:  tbyte = CH_START;
		endcase
	end

	always_comb begin
		tst_d   = tst_q;
		tcnt_d  = tcnt_q;
		twait_d = twait_q;
		tsh_d   = tsh_q;
		tbits_d = tbits_q;
		tidx_d  = tidx_q;
		case (tst_q)
			T_IDLE: if (go_tx) begin
				twait_d = wait_q;
				tcnt_d  = line_q.div;
				tst_d   = T_WAIT;
			end
			T_WAIT: if (twait_q == '0) begin
				tsh_d   = mk_char(CH_START, line_q);
				tbits_d = char_len(line_q);
				tidx_d  = IDX_START;
				tcnt_d  = line_q.div;
				tst_d   = T_SEND;
			end else if (tcnt_q == '0) begin
				tcnt_d  = line_q.div;
				twait_d = twait_q - 16'h0001;
			end else
				tcnt_d = tcnt_q - 16'h0001;
			T_SEND: if (tcnt_q == '0) begin
				tcnt_d = line_q.div;
				if (tbits_q == BITS_ONE) begin
					if (tidx_q == IDX_LAST)
						tst_d = T_IDLE;
					else begin
						tidx_d  = tidx_q + 3'h1;
						tsh_d   = mk_char(tbyte, line_q);
						tbits_d = char_len(line_q);
					end
				end else begin
					tsh_d   = {1'b1, tsh_q[CHAR_W-1:1]};
					tbits_d = tbits_q - BITS_ONE;
				end
			end else
				tcnt_d = tcnt_q - 16'h0001;
			default: tst_d = T_IDLE;
		endcase
		tx_oe_d = tst_d == T_SEND;
		tx_d    = (tst_d == T_SEND) ? tsh_d[0] : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tst_q   <= T_IDLE;
			tcnt_q  <= '0;
			twait_q <= '0;
			tsh_q   <= '1;
			tbits_q <= '0;
			tidx_q  <= IDX_START;
			tx_q    <= 1'b1;
			tx_oe_q <= 1'b0;
		end else if (ce) begin
			tst_q   <= tst_d;
			tcnt_q  <= tcnt_d;
			twait_q <= twait_d;
			tsh_q   <= tsh_d;
			tbits_q <= tbits_d;
			tidx_q  <= tidx_d;
			tx_q    <= tx_d;
			tx_oe_q <= tx_oe_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign tx_pin  = tx_q;
	assign tx_oe   = tx_oe_q;
	assign cmd_stb = cmd_stb_q;
	assign cmd_out = cmd_q;

endmodule

// *** verif/ascr_responder_props.sv ***
// Port checker for the serial command responder
`timescale 1ns/1ps
module ascr_responder_props
	import ascr_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// Line and command
	input wire logic        tx_pin,
	input wire logic        tx_oe,
	input wire logic        cmd_stb,
	input wire ascr_cmd_t   cmd_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_stb_single: assert property (cmd_stb |=> !cmd_stb)
		else $error("command strobe longer than one cycle");
	a_cmd_stable: assert property (!cmd_stb |-> $stable(cmd_out))
		else $error("command output changed without strobe");
	a_bcast_quiet: assert property (
		cmd_stb && cmd_out.bcast && !tx_oe |=> !tx_oe[*8])
		else $error("driver enabled after broadcast");
	a_start_low: assert property ($rose(tx_oe) |-> !tx_pin)
		else $error("response does not open with a start bit");
	a_oe_frame: assert property ($rose(tx_oe) |-> tx_oe[*8])
		else $error("driver enable too short");
	a_idle_high: assert property (!tx_oe |-> tx_pin)
		else $error("transmit line not idle high");
	a_zero_wait: assert property (ce && psel && !penable |=> pready)
		else $error("ready missing in access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response without ready or zero data");
endmodule
bind ascr_responder ascr_responder_props u_props (.pclk(pclk),
	.presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .prdata(prdata), .tx_pin(tx_pin),
	.tx_oe(tx_oe), .cmd_stb(cmd_stb), .cmd_out(cmd_out));

// *** verif/ascr_host_model.sv ***
// Host controller model polling nodes over the serial line
`timescale 1ns/1ps
module ascr_host_model
	import ascr_pkg::*;
#(
	parameter int BIT_CYC = 4
)(
	// Clock and line
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	initial line_out = 1'b1;
	// Drop line noise until the line has idled one character time
	task automatic flush(output logic ok);
		int q, n;
		q = 0;
		n = 0;
		while (q < 10 * BIT_CYC && n < 400) begin
			@(posedge pclk);
			q = (line_in === 1'b1) ? q + 1 : 0;
			n++;
		end
		ok = (q >= 10 * BIT_CYC);
	endtask
	// One 8N1 character, stop bit forced low when bad is set
	task automatic put(input logic [7:0] b, input logic bad);
		logic [9:0] f;
		f = {~bad, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (BIT_CYC) @(posedge pclk);
		end
	endtask
	// Unit numbers are chosen distinct by the bench
	task automatic send(input logic [7:0] u, c, a, input logic bad);
		put(CH_START, 1'b0);
		put(u, 1'b0);
		put(c, 1'b0);
		put(a, bad);
		put(CH_END, 1'b0);
	endtask
	// Timeout exceeds send-wait plus a whole response
	task automatic get(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (line_in !== 1'b0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		ok = (n < 400);
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge pclk);
			b[i] = line_in;
		end
		repeat (BIT_CYC) @(posedge pclk);
	endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the serial command responder
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("ERROR %0t got %h want %h", $time, a, e); end end
module tb;
	import ascr_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        rx_pin, tx_pin, tx_oe, cmd_stb, host_rx, ok;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, prdata, r;
	ascr_cmd_t   cmd_out;
	int          error_cnt, compares, cyc, stb_n, oe_n, stb_c, oe_c;
	assign host_rx = tx_oe ? tx_pin : 1'b1;
	ascr_responder dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe),
		.cmd_stb(cmd_stb), .cmd_out(cmd_out));
	ascr_host_model #(.BIT_CYC(4)) host (.pclk(pclk), .line_in(host_rx),
		.line_out(rx_pin));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cmd_stb === 1'b1) begin
			stb_n++;
			stb_c = cyc;
		end
		if (tx_oe === 1'b1) begin
			if (oe_n == 0) oe_c = cyc;
			oe_n++;
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		b = {7'h00, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) begin
			error_cnt++;
			$display("ERROR %0t bus ready timeout", $time);
			end_of_test();
		end
	endtask
	task automatic addressed(input logic [7:0] c, a);
		logic [7:0] exp [5];
		stb_n = 0;
		oe_n = 0;
		exp = '{CH_START, 8'h05, c, 8'hA5, CH_END};
		host.send(8'h05, c, a, 1'b0);
		for (int i = 0; i < 5; i++) begin
			host.get(b, ok);
			`CHK(ok, 1'b1)
			if (ok !== 1'b1) end_of_test();
			`CHK(b, exp[i])
		end
		`CHK(stb_n, 1)
		`CHK(cmd_out, {1'b0, c, a})
		`CHK(oe_c - stb_c >= 4 && oe_c - stb_c <= 12, 1'b1)
	endtask
	task automatic silent(input logic [7:0] u, c, input logic bad);
		stb_n = 0;
		oe_n = 0;
		host.send(u, c, 8'h11, bad);
		repeat (120) @(posedge pclk);
		`CHK(oe_n, 0)
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, A_UNIT, 32'h0);
		`CHK(r, 32'h0000_0001)
		apb(1'b0, 8'h18, 32'h0);
		`CHK(b[0], 1'b1)
		apb(1'b1, A_LINE, 32'h0000_0003);
		apb(1'b1, A_WAIT, 32'h0000_0001);
		apb(1'b1, A_UNIT, 32'h0000_0005);
		apb(1'b1, A_RESP, 32'h0000_00A5);
		host.flush(ok);
		`CHK(ok, 1'b1)
		addressed(8'h31, 8'h42);
		repeat (HOST_GAP_CYC) @(posedge pclk);
		silent(8'h06, 8'h32, 1'b0);
		`CHK(stb_n, 0)
		silent(UNIT_BCAST, 8'h33, 1'b0);
		`CHK(stb_n, 1)
		`CHK(cmd_out, {1'b1, 8'h33, 8'h11})
		silent(8'h05, 8'h34, 1'b1);
		`CHK(stb_n, 0)
		apb(1'b0, A_STAT, 32'h0);
		`CHK(r[2], 1'b1)
		addressed(8'h35, 8'h46);
		end_of_test();
	end
endmodule
